// >>> diff_calc.sv
// Bias, differential and characteristic current of one element.
`timescale 1ns/10ps
module diff_calc #(
  parameter logic [15:0] pickup = 16'h0100
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] side_a,
  input wire logic [15:0] side_b,
  output logic [15:0] bias,
  output logic [15:0] diff,
  output logic [15:0] allowed,
  output logic over
);
  // ==========================================================
  // Combinational terms; the sum is one bit wider to avoid wrap.
  logic [16:0] sum; // Sum of both sides.
  logic [15:0] next_bias; // Mean of both sides.
  logic [15:0] next_diff; // Magnitude of the difference.
  logic [16:0] next_allowed; // Pickup plus half the bias.

  always_comb begin
    sum = {1'b0, side_a} + {1'b0, side_b};
    next_bias = sum[16:1];
    if (side_a > side_b) begin
      next_diff = side_a - side_b;
    end else begin
      next_diff = side_b - side_a;
    end
    next_allowed = {1'b0, pickup} + {2'b00, next_bias[15:1]};
  end

  // ==========================================================
  // Registered results; the allowed current saturates at full scale.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bias <= 16'h0000;
      diff <= 16'h0000;
      allowed <= 16'h0000;
      over <= 1'b0;
    end else begin
      bias <= next_bias;
      diff <= next_diff;
      if (next_allowed[16]) begin
        allowed <= 16'hffff;
        over <= 1'b0;
      end else begin
        allowed <= next_allowed[15:0];
        over <= next_diff > next_allowed[15:0];
      end
    end
  end
endmodule

// >>> diff_prot_pkg.sv
// Constants shared by the differential protection event recorder.
package diff_prot_pkg;
  // ==========================================================
  // Register byte offsets on the APB bus.
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] evt_mask_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;
  localparam logic [7:0] irq_stat_off = 8'h0c;
  localparam logic [7:0] irq_mask_off = 8'h10;
  localparam logic [7:0] cnt_trip_off = 8'h14;
  localparam logic [7:0] cnt_h2_off = 8'h18;
  localparam logic [7:0] cnt_h5_off = 8'h1c;
  localparam logic [7:0] cnt_ext_off = 8'h20;
  localparam logic [7:0] rec_sel_off = 8'h24;
  localparam logic [7:0] rec_win_off = 8'h80;
  // ==========================================================
  // Control fields and their values after reset.
  localparam int harm_sel_pos = 0;
  localparam int nb_en_pos = 2;
  localparam int cnt_clr_pos = 3;
  localparam logic [1:0] harm_sel_rst = 2'h1;
  localparam logic nb_en_rst = 1'b1;
  localparam logic [31:0] evt_mask_rst = 32'hffff_ffff;
  // ==========================================================
  // Status vector layout; each bit yields an ON and an OFF event.
  localparam int st_bias_trip = 0;
  localparam int st_bias_blk = 1;
  localparam int st_nb_trip = 2;
  localparam int st_nb_blk = 3;
  localparam int st_h2_blk = 4;
  localparam int st_h5_blk = 5;
  localparam int st_h2_ph = 6;
  localparam int st_h5_ph = 9;
  localparam int st_hv_blk = 12;
  localparam int st_hv_trip = 13;
  localparam int st_lv_blk = 14;
  localparam int st_lv_trip = 15;
  localparam int n_status = 16;
  // ==========================================================
  // Operation record store.
  localparam int n_rec = 12;
  localparam int rec_words = 18;
  localparam int n_calc = 5;
  // ==========================================================
  // Characteristic settings in current units.
  localparam logic [15:0] pickup_phase = 16'h0100;
  localparam logic [15:0] pickup_ref = 16'h0080;
  localparam logic [15:0] pickup_nobias = 16'h1800;
endpackage

// >>> diff_prot_recorder.sv
// Event, counter and operation record logic of differential protection.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
module diff_prot_recorder (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] phase1_hv_current,
  input wire logic [15:0] phase2_hv_current,
  input wire logic [15:0] phase3_hv_current,
  input wire logic [15:0] phase1_lv_current,
  input wire logic [15:0] phase2_lv_current,
  input wire logic [15:0] phase3_lv_current,
  input wire logic [15:0] hv_neutral_current,
  input wire logic [15:0] hv_residual_current,
  input wire logic [15:0] lv_neutral_current,
  input wire logic [15:0] lv_residual_current,
  input wire logic [2:0] h2_detect,
  input wire logic [2:0] h5_detect,
  input wire logic ext_block_bias,
  input wire logic ext_block_nobias,
  input wire logic ext_block_hv,
  input wire logic ext_block_lv,
  input wire logic [47:0] time_ms,
  input wire logic [1:0] setting_group,
  output logic bias_trip,
  output logic nobias_trip,
  output logic bias_blocked,
  output logic nobias_blocked,
  output logic h2_block,
  output logic h5_block,
  output logic hv_ref_trip,
  output logic hv_ref_blocked,
  output logic lv_ref_trip,
  output logic lv_ref_blocked,
  output logic evt_valid,
  output logic [4:0] evt_code,
  output logic [47:0] evt_stamp,
  output logic irq
);
  // ==========================================================
  // Per-element calculation: three phases, then the two earth sides.
  logic [15:0] calc_a [0:4]; // First side of each element.
  logic [15:0] calc_b [0:4]; // Second side of each element.
  logic [15:0] bias [0:4]; // Bias current per element.
  logic [15:0] diff [0:4]; // Differential current per element.
  logic [15:0] allowed [0:4]; // Characteristic current per element.
  logic [4:0] over; // Differential above characteristic.

  assign calc_a[0] = phase1_hv_current;
  assign calc_a[1] = phase2_hv_current;
  assign calc_a[2] = phase3_hv_current;
  assign calc_a[3] = hv_neutral_current;
  assign calc_a[4] = lv_neutral_current;
  assign calc_b[0] = phase1_lv_current;
  assign calc_b[1] = phase2_lv_current;
  assign calc_b[2] = phase3_lv_current;
  assign calc_b[3] = hv_residual_current;
  assign calc_b[4] = lv_residual_current;

  for (genvar g = 0; g < diff_prot_pkg::n_calc; g++) begin : g_calc
    diff_calc #(
      .pickup(g < 3 ? diff_prot_pkg::pickup_phase
                    : diff_prot_pkg::pickup_ref)
    ) u_calc (
      .clk_sys(clk_sys),
      .reset(reset),
      .side_a(calc_a[g]),
      .side_b(calc_b[g]),
      .bias(bias[g]),
      .diff(diff[g]),
      .allowed(allowed[g]),
      .over(over[g])
    );
  end

  // ==========================================================
  // Pin synchroniser for the external blocking inputs.
  logic [3:0] ext_s1; // First stage, read only by the second.
  logic [3:0] ext_s2; // Second stage.
  logic [3:0] ext_s3; // Third stage.
  logic [3:0] ext_f; // Filtered level: bias, nobias, hv, lv.

  // A change is accepted only once two stages agree, so a glitch
  // shorter than a clock never reaches the filtered level ext_f.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_s1 <= 4'h0;
      ext_s2 <= 4'h0;
      ext_s3 <= 4'h0;
      ext_f <= 4'h0;
    end else begin
      ext_s1 <= {ext_block_lv, ext_block_hv,
                 ext_block_nobias, ext_block_bias};
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      for (int i = 0; i < 4; i++) begin
        if (ext_s2[i] == ext_s3[i]) begin
          ext_f[i] <= ext_s3[i];
        end
      end
    end
  end

  // ==========================================================
  // Software registers.
  logic [1:0] harm_sel; // Bit 0 enables 2nd, bit 1 enables 5th.
  logic nb_en; // Enables the non-biased stage.
  logic [31:0] evt_mask; // Low half ON enables, high half OFF.
  logic [2:0] irq_stat; // Sticky: operation, event, drop.
  logic [2:0] irq_mask; // Enables for the sticky bits.
  logic [3:0] rec_sel; // Record age to read, 0 is newest.
  logic cnt_clr; // One-cycle counter clear request.
  logic wr_acc; // Write access phase.
  logic rd_setup; // Read setup phase.

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // ==========================================================
  // Status vector and its previous value for edge detection.
  logic [15:0] next_status; // Status computed this cycle.
  logic [15:0] status; // Registered status.
  logic [15:0] status_q; // Status one cycle earlier.
  logic [2:0] nb_over; // Differential above the non-biased pickup.
  logic h2_any; // Enabled 2nd harmonic detection.
  logic h5_any; // Enabled 5th harmonic detection.

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      nb_over[p] = diff[p] > diff_prot_pkg::pickup_nobias;
    end
    h2_any = harm_sel[0] && (|h2_detect);
    h5_any = harm_sel[1] && (|h5_detect);
    next_status = 16'h0000;
    // Harmonic blocking holds the biased stage off during inrush.
    next_status[diff_prot_pkg::st_bias_trip] =
      (|over[2:0]) && !ext_f[0] && !h2_any && !h5_any;
    next_status[diff_prot_pkg::st_bias_blk] = ext_f[0];
    next_status[diff_prot_pkg::st_nb_trip] =
      nb_en && (|nb_over) && !ext_f[1];
    next_status[diff_prot_pkg::st_nb_blk] = ext_f[1];
    next_status[diff_prot_pkg::st_h2_blk] = h2_any;
    next_status[diff_prot_pkg::st_h5_blk] = h5_any;
    next_status[diff_prot_pkg::st_h2_ph +: 3] =
      h2_detect & {3{harm_sel[0]}};
    next_status[diff_prot_pkg::st_h5_ph +: 3] =
      h5_detect & {3{harm_sel[1]}};
    next_status[diff_prot_pkg::st_hv_blk] = ext_f[2];
    next_status[diff_prot_pkg::st_hv_trip] = over[3] && !ext_f[2];
    next_status[diff_prot_pkg::st_lv_blk] = ext_f[3];
    next_status[diff_prot_pkg::st_lv_trip] = over[4] && !ext_f[3];
  end

  // Status register; the stage outputs are taken straight from it.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status <= 16'h0000;
      status_q <= 16'h0000;
    end else begin
      status <= next_status;
      status_q <= status;
    end
  end

  assign bias_trip = status[diff_prot_pkg::st_bias_trip];
  assign bias_blocked = status[diff_prot_pkg::st_bias_blk];
  assign nobias_trip = status[diff_prot_pkg::st_nb_trip];
  assign nobias_blocked = status[diff_prot_pkg::st_nb_blk];
  assign h2_block = status[diff_prot_pkg::st_h2_blk];
  assign h5_block = status[diff_prot_pkg::st_h5_blk];
  assign hv_ref_blocked = status[diff_prot_pkg::st_hv_blk];
  assign hv_ref_trip = status[diff_prot_pkg::st_hv_trip];
  assign lv_ref_blocked = status[diff_prot_pkg::st_lv_blk];
  assign lv_ref_trip = status[diff_prot_pkg::st_lv_trip];

  // ==========================================================
  // Event pending flags and their time stamps.
  logic [15:0] rise; // Status bits that went on.
  logic [15:0] fall; // Status bits that went off.
  logic [31:0] pend; // Pending events, code = 2*bit + off.
  logic [47:0] stamp [0:31]; // Time of each pending change.
  logic pick_ok; // Some event is pending.
  logic [4:0] pick; // Lowest pending event code.

  assign rise = status & ~status_q;
  assign fall = ~status & status_q;

  always_comb begin
    pick_ok = 1'b0;
    pick = 5'h00;
    for (int e = 31; e >= 0; e--) begin
      if (pend[e]) begin
        pick_ok = 1'b1;
        pick = e[4:0];
      end
    end
  end

  // A new change on the emitted code wins over its clear.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend <= 32'h0000_0000;
    end else begin
      for (int e = 0; e < 32; e++) begin
        if (e[0] ? fall[e / 2] : rise[e / 2]) begin
          pend[e] <= 1'b1;
          stamp[e] <= time_ms;
        end else if (pick_ok && pick == e[4:0]) begin
          pend[e] <= 1'b0;
        end
      end
    end
  end

  // The mask gates the buffer write and, when clear, sets the drop flag; status and counters go on.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      evt_valid <= 1'b0;
      evt_code <= 5'h00;
      evt_stamp <= 48'h0000_0000_0000;
    end else begin
      evt_valid <= pick_ok &&
        evt_mask[{pick[0], pick[4:1]}];
      evt_code <= pick;
      evt_stamp <= stamp[pick];
    end
  end

  // ==========================================================
  // Cumulative counters, cleared together by software.
  logic [31:0] cnt_trip; // Trip events.
  logic [31:0] cnt_h2; // 2nd harmonic block events.
  logic [31:0] cnt_h5; // 5th harmonic block events.
  logic [31:0] cnt_ext; // External block events.
  logic trip_rise; // Any trip went on.

  assign trip_rise = rise[0] || rise[2] || rise[13] || rise[15];

  always_ff @(posedge clk_sys) begin
    if (reset || cnt_clr) begin
      cnt_trip <= 32'h0000_0000;
      cnt_h2 <= 32'h0000_0000;
      cnt_h5 <= 32'h0000_0000;
      cnt_ext <= 32'h0000_0000;
    end else begin
      cnt_trip <= cnt_trip + 32'(trip_rise);
      cnt_h2 <= cnt_h2 + 32'(rise[diff_prot_pkg::st_h2_blk]);
      cnt_h5 <= cnt_h5 + 32'(rise[diff_prot_pkg::st_h5_blk]);
      cnt_ext <= cnt_ext + 32'(rise[1] || rise[3] || rise[12] ||
                               rise[14]);
    end
  end

  // ==========================================================
  // Operation record ring of twelve entries of eighteen words.
  logic [31:0] rec_mem [0:215]; // Record words, slot major.
  logic [3:0] wr_ptr; // Next slot to write.
  logic [3:0] rec_count; // Records held, at most twelve.
  logic [4:0] trip_code; // Status bit of the lowest rising trip.
  logic [4:0] rd_slot; // Slot selected for reading.

  always_comb begin
    trip_code = 5'h00;
    for (int t = 15; t >= 0; t--) begin
      if (rise[t] && (t == 0 || t == 2 || t == 13 || t == 15)) begin
        trip_code = t[4:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr <= 4'h0;
      rec_count <= 4'h0;
    end else if (trip_rise) begin
      for (int k = 0; k < 15; k++) begin
        rec_mem[wr_ptr * 18 + k] <= {
          k % 3 == 0 ? bias[k / 3] : 16'h0000,
          k % 3 == 1 ? diff[k / 3] :
          (k % 3 == 2 ? allowed[k / 3] : 16'h0000)};
      end
      rec_mem[wr_ptr * 18 + 15] <= time_ms[31:0];
      rec_mem[wr_ptr * 18 + 16] <=
        {11'h000, trip_code, time_ms[47:32]};
      rec_mem[wr_ptr * 18 + 17] <=
        {22'h00_0000, setting_group, 3'h0, over};
      // Past the end the ring wraps and the oldest entry goes.
      wr_ptr <= (wr_ptr == 4'(diff_prot_pkg::n_rec - 1)) ?
        4'h0 : wr_ptr + 4'h1;
      if (rec_count != 4'(diff_prot_pkg::n_rec)) begin
        rec_count <= rec_count + 4'h1;
      end
    end
  end

  // Six bits hold the sum: the write pointer plus 23 can reach 34.
  assign rd_slot = 5'((6'(wr_ptr) + 6'd23 - 6'(rec_sel)) % 6'd12);

  // ==========================================================
  // Register writes; sticky bits set by hardware win over W1C.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      harm_sel <= diff_prot_pkg::harm_sel_rst;
      nb_en <= diff_prot_pkg::nb_en_rst;
      evt_mask <= diff_prot_pkg::evt_mask_rst;
      irq_mask <= 3'h0;
      irq_stat <= 3'h0;
      rec_sel <= 4'h0;
      cnt_clr <= 1'b0;
    end else begin
      cnt_clr <= wr_acc && paddr == diff_prot_pkg::ctrl_off &&
                 pwdata[diff_prot_pkg::cnt_clr_pos];
      if (wr_acc && paddr == diff_prot_pkg::ctrl_off) begin
        harm_sel <= pwdata[diff_prot_pkg::harm_sel_pos +: 2];
        nb_en <= pwdata[diff_prot_pkg::nb_en_pos];
      end else if (wr_acc && paddr == diff_prot_pkg::evt_mask_off) begin
        evt_mask <= pwdata;
      end else if (wr_acc && paddr == diff_prot_pkg::irq_mask_off) begin
        irq_mask <= pwdata[2:0];
      end else if (wr_acc && paddr == diff_prot_pkg::rec_sel_off) begin
        rec_sel <= pwdata[3:0];
      end
      for (int b = 0; b < 3; b++) begin
        if ((b == 0 && trip_rise) || (b == 1 && evt_valid) ||
            (b == 2 && pick_ok && !evt_mask[{pick[0], pick[4:1]}])) begin
          irq_stat[b] <= 1'b1;
        end else if (wr_acc && paddr == diff_prot_pkg::irq_stat_off &&
                     pwdata[b]) begin
          irq_stat[b] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ==========================================================
  // Read data is latched in the setup cycle, ready in the access.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (paddr == diff_prot_pkg::ctrl_off) begin
        prdata <= {29'h0, nb_en, harm_sel};
      end else if (paddr == diff_prot_pkg::evt_mask_off) begin
        prdata <= evt_mask;
      end else if (paddr == diff_prot_pkg::status_off) begin
        prdata <= {16'h0000, status};
      end else if (paddr == diff_prot_pkg::irq_stat_off) begin
        prdata <= {29'h0, irq_stat};
      end else if (paddr == diff_prot_pkg::irq_mask_off) begin
        prdata <= {29'h0, irq_mask};
      end else if (paddr == diff_prot_pkg::cnt_trip_off) begin
        prdata <= cnt_trip;
      end else if (paddr == diff_prot_pkg::cnt_h2_off) begin
        prdata <= cnt_h2;
      end else if (paddr == diff_prot_pkg::cnt_h5_off) begin
        prdata <= cnt_h5;
      end else if (paddr == diff_prot_pkg::cnt_ext_off) begin
        prdata <= cnt_ext;
      end else if (paddr == diff_prot_pkg::rec_sel_off) begin
        prdata <= {20'h0, rec_count, 4'h0, rec_sel};
      end else if (paddr >= diff_prot_pkg::rec_win_off &&
                   paddr < 8'hc8 && paddr[1:0] == 2'b00 &&
                   rd_setup && {1'b0, rec_sel} < 5'(rec_count)) begin
        prdata <= rec_mem[rd_slot * 18 + 32'(paddr[6:2])];
      end else if (!(paddr >= diff_prot_pkg::rec_win_off &&
                     paddr < 8'hc8 && paddr[1:0] == 2'b00)) begin
        pslverr <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_ext_blocks_trip: assert property (ext_f[0] |-> ##2 !bias_trip)
    else $error("biased trip while externally blocked");
  a_nb_disabled: assert property (!nb_en ##1 !nb_en |-> ##1 !nobias_trip)
    else $error("non-biased trip while disabled");
  a_harm_sel_off: assert property (!harm_sel[0] [*2] |-> !h2_block)
    else $error("2nd harmonic block while not selected");
  a_evt_mask: assert property (evt_valid |->
    $past(evt_mask[{pick[0], pick[4:1]}]))
    else $error("masked event written");
  a_change_pends: assert property (rise[4] |=> pend[8])
    else $error("status change lost");
  a_trip_count: assert property (trip_rise && !cnt_clr |=>
    cnt_trip == $past(cnt_trip) + 32'h1)
    else $error("trip counter missed");
  a_rec_bound: assert property (rec_count <= 4'd12 && wr_ptr < 4'd12)
    else $error("record ring out of range");
  a_rec_grow: assert property (trip_rise && rec_count < 4'd12 |=>
    rec_count == $past(rec_count) + 4'h1)
    else $error("record not stored");
  a_stage_out: assert property (lv_ref_trip |->
    $past(over[4]) && !$past(ext_f[3]))
    else $error("earth fault trip without its cause");

  c_trip_event: cover property (rise[0] ##[1:40] evt_valid);
  c_ring_wrap: cover property (trip_rise && rec_count == 4'd12);
  c_masked: cover property (pick_ok && !evt_mask[{pick[0], pick[4:1]}]);
endmodule

// >>> diff_protection_event_recorder_tb.sv
// Self-checking bench of the differential protection recorder.
`timescale 1ns/10ps
module diff_protection_event_recorder_tb;
  // ==========================================
  // Stimulus and observed signals
  logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, evt_valid, irq;
  logic [15:0] cur [10]; // Phase, then earth side currents.
  logic [2:0] h2_detect = 3'h0, h5_detect = 3'h0;
  logic [3:0] ext = 4'h0; // External block pins.
  logic [47:0] time_ms = 48'h0, t0, t_keep, evt_stamp;
  logic [1:0] setting_group = 2'h2;
  logic [9:0] stage; // Stage outputs in port order.
  logic [4:0] evt_code;
  int bad_count = 0, checks_done = 0;

  diff_prot_recorder dut (.clk_sys, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr,
    .phase1_hv_current(cur[0]), .phase2_hv_current(cur[1]),
    .phase3_hv_current(cur[2]), .phase1_lv_current(cur[3]),
    .phase2_lv_current(cur[4]), .phase3_lv_current(cur[5]),
    .hv_neutral_current(cur[6]), .hv_residual_current(cur[7]),
    .lv_neutral_current(cur[8]), .lv_residual_current(cur[9]),
    .h2_detect, .h5_detect, .ext_block_bias(ext[0]),
    .ext_block_nobias(ext[1]), .ext_block_hv(ext[2]), .ext_block_lv(ext[3]),
    .time_ms, .setting_group, .bias_trip(stage[0]), .nobias_trip(stage[1]),
    .bias_blocked(stage[2]), .nobias_blocked(stage[3]),
    .h2_block(stage[4]), .h5_block(stage[5]), .hv_ref_trip(stage[6]),
    .hv_ref_blocked(stage[7]), .lv_ref_trip(stage[8]),
    .lv_ref_blocked(stage[9]), .evt_valid, .evt_code, .evt_stamp, .irq);
  event_sink sink (.clk_sys, .evt_valid, .evt_code, .evt_stamp);

  // Clock of 20 ns and a millisecond base that simply counts cycles.
  initial forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) time_ms <= time_ms + 48'h1;

  // ==========================================
  // Shared tasks
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      results();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Drive the phase 1 unbalance that exceeds the biased characteristic.
  task automatic trip(input logic on);
    @(posedge clk_sys);
    cur[0] <= on ? 16'h1000 : 16'h0000;
    t0 = time_ms;
  endtask
  // Waits, bounded, for the next logged event and judges it.
  task automatic want_evt(input logic [4:0] code);
    logic [52:0] e;
    int n;
    n = 0;
    while (sink.log_q.size() == 0 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      results();
    end
    e = sink.log_q.pop_front();
    chk("evt_code", {43'h0, code}, {43'h0, e[52:48]});
    chk("evt_late", 48'h0, {47'h0, e[47:0] < t0 || e[47:0] > t0 + 10});
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    apb(diff_prot_pkg::ctrl_off, 0, 0);
    chk("ctrl", 48'h5, {16'h0, rd});
    apb(diff_prot_pkg::evt_mask_off, 0, 0);
    chk("evt_mask", 48'hffff_ffff, {16'h0, rd});
    apb(8'h28, 0, 0);
    chk("unmapped", 48'h1_0000_0000, {15'h0, er, rd});
    $display("done reset");
  endtask
  task automatic t_trip();
    trip(1);
    want_evt(5'h0);
    chk("stages", 48'h1, {38'h0, stage});
    apb(diff_prot_pkg::rec_win_off, 0, 0);
    chk("bias", 48'h0800, {32'h0, rd[31:16]});
    apb(diff_prot_pkg::rec_win_off + 8'h4, 0, 0);
    chk("diff", 48'h1000, {32'h0, rd[15:0]});
    apb(diff_prot_pkg::rec_win_off + 8'h8, 0, 0);
    chk("char", 48'h0500, {32'h0, rd[15:0]});
    apb(diff_prot_pkg::rec_win_off + 8'h44, 0, 0);
    chk("grp_ftype", 48'h0201, {16'h0, rd});
    apb(diff_prot_pkg::cnt_trip_off, 0, 0);
    chk("cnt_trip", 48'h1, {16'h0, rd});
    trip(0);
    want_evt(5'h1);
    $display("done trip");
  endtask
  task automatic t_mask();
    apb(diff_prot_pkg::irq_mask_off, 1, 32'h4);
    apb(diff_prot_pkg::evt_mask_off, 1, 32'hffff_fffe);
    trip(1);
    repeat (12) @(posedge clk_sys);
    chk("masked_on", 48'h0, {16'h0, sink.log_q.size()});
    apb(diff_prot_pkg::status_off, 0, 0);
    chk("status", 48'h1, {47'h0, rd[0]});
    chk("irq_on", 48'h1, {47'h0, irq});
    apb(diff_prot_pkg::irq_stat_off, 1, 32'h4);
    @(posedge clk_sys);
    chk("irq_off", 48'h0, {47'h0, irq});
    trip(0);
    want_evt(5'h1);
    apb(diff_prot_pkg::evt_mask_off, 1, 32'hffff_ffff);
    $display("done mask");
  endtask
  task automatic t_ext();
    @(posedge clk_sys);
    ext[0] <= 1'b1;
    t0 = time_ms;
    want_evt(5'h2);
    chk("blocked", 48'h1, {47'h0, stage[2]});
    apb(diff_prot_pkg::cnt_ext_off, 0, 0);
    chk("cnt_ext", 48'h1, {16'h0, rd});
    ext[0] <= 1'b0;
    t0 = time_ms;
    want_evt(5'h3);
    apb(diff_prot_pkg::ctrl_off, 1, 32'hd);
    apb(diff_prot_pkg::cnt_trip_off, 0, 0);
    chk("cnt_clear", 48'h0, {16'h0, rd});
    $display("done ext");
  endtask
  // 2nd harmonic on phase 1, then deselected; also clears nb_en.
  task automatic t_harm();
    @(posedge clk_sys);
    h2_detect <= 3'h1;
    t0 = time_ms;
    want_evt(5'h8);
    want_evt(5'hc);
    chk("h2_block", 48'h1, {47'h0, stage[4]});
    apb(diff_prot_pkg::ctrl_off, 1, 32'h2);
    t0 = time_ms;
    apb(diff_prot_pkg::ctrl_off, 0, 0);
    chk("ctrl_wr", 48'h2, {16'h0, rd});
    want_evt(5'h9);
    want_evt(5'hd);
    apb(diff_prot_pkg::cnt_h2_off, 0, 0);
    chk("cnt_h2", 48'h1, {16'h0, rd});
    h2_detect <= 3'h0;
    $display("done harm");
  endtask
  task automatic t_rec();
    for (int i = 0; i < 13; i++) begin
      trip(1);
      if (i == 1) t_keep = t0;
      want_evt(5'h0);
      trip(0);
      want_evt(5'h1);
    end
    apb(diff_prot_pkg::rec_sel_off, 1, 32'hb);
    apb(diff_prot_pkg::rec_sel_off, 0, 0);
    chk("rec_count", 48'hc, {44'h0, rd[11:8]});
    apb(diff_prot_pkg::rec_win_off + 8'h3c, 0, 0);
    chk("oldest", 48'h0, {47'h0, rd - t_keep[31:0] > 32'ha});
    $display("done records");
  endtask

  // Main sequence: reset two cycles, then every scenario in turn.
  initial begin
    foreach (cur[i]) cur[i] = 16'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_trip();
    t_mask();
    t_ext();
    t_harm();
    t_rec();
    results();
  end
endmodule

// >>> event_sink.sv
// Host model that logs every event the recorder writes out.
`timescale 1ns/10ps
module event_sink (
  input wire logic clk_sys,
  input wire logic evt_valid,
  input wire logic [4:0] evt_code,
  input wire logic [47:0] evt_stamp
);
  // ==========================================
  // Event log
  // Code and stamp of each write, oldest first.
  logic [52:0] log_q[$];
  // The write pulse stands one cycle, so it is taken at that very edge.
  always @(posedge clk_sys) begin
    if (evt_valid === 1'b1) begin
      log_q.push_back({evt_code, evt_stamp});
    end
  end
endmodule
